/* icc_regs.vh */
// offsets, field positions, reset value and counts of the input check control
`ifndef ICC_REGS_VH
`define ICC_REGS_VH

`define ICC_CTRL_ADDR 7'h01
`define ICC_CTRL_RESET 16'h050E

`define ICC_BIT_PATTERN_TEST 15
`define ICC_BIT_GOOD_CLEAR 12
`define ICC_BIT_PARITY_ODD 11
`define ICC_BIT_WORD_PARITY 10
`define ICC_BIT_STROBE_PARITY 9
`define ICC_BIT_RESERVED_EIGHT 8
`define ICC_BIT_IN_PHASE_INV 6
`define ICC_BIT_QUAD_INV 5
`define ICC_BIT_TWO_APART 3
`define ICC_BIT_ONE_APART 2
`define ICC_BIT_COLLISION 1

`define ICC_GOOD_RUN 7'h40
`define ICC_HDR_LAST 5'h07
`define ICC_FRAME_LAST 5'h17

`endif

/* icc_parity_check.v */
// parity checker for one input word against a selectable parity source
module icc_parity_check (
  input wire i_clk_sys, // system clock
  input wire i_reset, // async reset, active high
  input wire i_check_enable, // word parity checking on
  input wire i_odd_sense, // 0 even, 1 odd
  input wire i_use_strobe, // take parity bit from strobe
  input wire i_valid, // word present this cycle
  input wire [15:0] i_word, // input data word
  input wire i_parity_dedicated, // dedicated parity bit
  input wire i_parity_strobe, // sample-group strobe bit
  output reg o_parity_error // one-cycle error pulse
);

  wire parity_bit;
  wire ones_odd;

  assign parity_bit = i_use_strobe ? i_parity_strobe : i_parity_dedicated;
  assign ones_odd = ^{i_word, parity_bit};

  // even sense wants an even count of ones over word plus parity
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_parity_error <= 1'b0;
    end else begin
      o_parity_error <= i_valid & (i_check_enable | i_use_strobe) &
        (ones_odd != i_odd_sense);
    end
  end

endmodule

/* icc_input_check.v */
// input check control register with serial access and the logic it steers
// Contract
// - pattern test bit 15 runs checker and forces both analog outputs off.
// - bit 12 clears alarms automatically after 64 consecutive good samples.
// - bit 11 picks parity sense, 0 even, 1 odd.
// - bit 10, set at reset, checks each word against dedicated parity.
// - bit 9 takes the parity bit from the strobe input instead.
// - bit 6 complements the in-phase channel data.
// - bit 5 complements the quadrature channel data.
// - bit 3, reset 1, passes the pointers-two-apart fifo alarm.
// - bit 2, reset 1, passes the pointers-one-apart fifo alarm.
// - bit 1, reset 1, passes the pointer collision fifo alarm.
// - register sits at address 0x01 and resets to 0x050E.
`include "icc_regs.vh"

module icc_input_check (
  input wire i_clk_sys, // system clock, 250 MHz
  input wire i_reset, // async reset, active high
  input wire i_serial_enable_n, // serial frame enable pin, low active
  input wire i_serial_clk, // serial clock pin
  input wire i_serial_data_in, // serial data pin, input side
  output reg o_serial_data_out, // serial data pin, output side
  output reg o_serial_data_oe, // serial data pin, high while driving
  input wire i_tx_enable_pin, // transmit enable pin
  input wire i_serial_tx_enable, // transmit enable from serial config
  input wire i_sample_valid, // a checked sample this cycle
  input wire i_sample_error, // that sample had an error
  input wire i_word_valid, // input word present this cycle
  input wire [15:0] i_word, // input word for parity checking
  input wire i_dedicated_parity_input, // dedicated parity bit
  input wire i_strobe_parity, // sample-group strobe as parity
  input wire [15:0] i_in_phase_data, // in-phase channel data
  input wire [15:0] i_quadrature_data, // quadrature channel data
  input wire i_fifo_two_apart, // fifo pointers two apart
  input wire i_fifo_one_apart, // fifo pointers one apart
  input wire i_fifo_collision, // fifo pointer collision
  output wire [15:0] o_input_check_control, // register contents
  output reg o_pattern_check_run, // pattern checker running
  output reg o_analog_outputs_enable, // analog outputs allowed on
  output reg o_alarm_auto_clear, // one-cycle alarm clear pulse
  output wire o_parity_error, // one-cycle parity error pulse
  output reg [15:0] o_in_phase_output, // in-phase data after inversion
  output reg [15:0] o_quadrature_output, // quadrature data after inversion
  output reg o_alarm_two_apart, // gated two-apart alarm
  output reg o_alarm_one_apart, // gated one-apart alarm
  output reg o_alarm_collision // gated collision alarm
);

  reg [15:0] input_check_control_r;

  // pin synchronisers: first stage feeds only the second
  reg en_n_s1_r;
  reg en_n_s2_r;
  reg sclk_s1_r;
  reg sclk_s2_r;
  reg sclk_d_r;
  reg sdi_s1_r;
  reg sdi_s2_r;
  reg txen_s1_r;
  reg txen_s2_r;

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      en_n_s1_r <= 1'b1;
      en_n_s2_r <= 1'b1;
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      sclk_d_r <= 1'b0;
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
      txen_s1_r <= 1'b0;
      txen_s2_r <= 1'b0;
    end else begin
      en_n_s1_r <= i_serial_enable_n;
      en_n_s2_r <= en_n_s1_r;
      sclk_s1_r <= i_serial_clk;
      sclk_s2_r <= sclk_s1_r;
      sclk_d_r <= sclk_s2_r;
      sdi_s1_r <= i_serial_data_in;
      sdi_s2_r <= sdi_s1_r;
      txen_s1_r <= i_tx_enable_pin;
      txen_s2_r <= txen_s1_r;
    end
  end

  wire sclk_rise;
  wire sclk_fall;
  wire in_frame;

  assign sclk_rise = sclk_s2_r & ~sclk_d_r;
  assign sclk_fall = ~sclk_s2_r & sclk_d_r;
  assign in_frame = ~en_n_s2_r;

  // serial frame: read flag, 7 address bits, 16 data bits, msb first
  reg [4:0] bit_cnt_r;
  reg [6:0] hdr_r;
  reg [14:0] wr_sh_r;
  reg [15:0] rd_sh_r;
  reg read_r;
  reg hit_r;
  reg past_hdr_r;
  wire [7:0] hdr_full;

  assign hdr_full = {hdr_r, sdi_s2_r};

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      bit_cnt_r <= 5'h00;
      hdr_r <= 7'h00;
      wr_sh_r <= 15'h0000;
      rd_sh_r <= 16'h0000;
      read_r <= 1'b0;
      hit_r <= 1'b0;
      past_hdr_r <= 1'b0;
      o_serial_data_out <= 1'b0;
      o_serial_data_oe <= 1'b0;
      input_check_control_r <= `ICC_CTRL_RESET;
    end else if (!in_frame) begin
      // frame end aborts any partial transfer and releases the pin
      bit_cnt_r <= 5'h00;
      past_hdr_r <= 1'b0;
      hit_r <= 1'b0;
      o_serial_data_oe <= 1'b0;
      // no read state of a cut frame survives into the next one
      read_r <= 1'b0;
      rd_sh_r <= 16'h0000;
      o_serial_data_out <= 1'b0;
    end else begin
      if (sclk_rise) begin
        if (bit_cnt_r != `ICC_FRAME_LAST) begin
          bit_cnt_r <= bit_cnt_r + 5'h01;
        end
        if (!past_hdr_r) begin
          hdr_r <= hdr_full[6:0];
          if (bit_cnt_r == `ICC_HDR_LAST) begin
            past_hdr_r <= 1'b1;
            read_r <= hdr_full[7];
            hit_r <= (hdr_full[6:0] == `ICC_CTRL_ADDR);
            rd_sh_r <= input_check_control_r;
          end
        end else begin
          wr_sh_r <= {wr_sh_r[13:0], sdi_s2_r};
          if (bit_cnt_r == `ICC_FRAME_LAST && !read_r && hit_r) begin
            // reserved bits are stored as written
            input_check_control_r <= {wr_sh_r, sdi_s2_r};
          end
          if (bit_cnt_r == `ICC_FRAME_LAST) begin
            hit_r <= 1'b0;
          end
        end
      end
      // read data changes on falling edges, valid for the next rise
      if (sclk_fall && past_hdr_r && read_r && hit_r) begin
        o_serial_data_out <= rd_sh_r[15];
        o_serial_data_oe <= 1'b1;
        rd_sh_r <= {rd_sh_r[14:0], 1'b0};
      end
      if (sclk_fall && !hit_r) begin
        o_serial_data_oe <= 1'b0;
      end
    end
  end

  assign o_input_check_control = input_check_control_r;

  wire test_on;
  wire good_clear_on;
  wire parity_odd_on;
  wire word_parity_on;
  wire strobe_parity_on;
  wire in_phase_inv_on;
  wire quad_inv_on;
  wire two_apart_on;
  wire one_apart_on;
  wire collision_on;

  assign test_on = input_check_control_r[`ICC_BIT_PATTERN_TEST];
  assign good_clear_on = input_check_control_r[`ICC_BIT_GOOD_CLEAR];
  assign parity_odd_on = input_check_control_r[`ICC_BIT_PARITY_ODD];
  assign word_parity_on = input_check_control_r[`ICC_BIT_WORD_PARITY];
  assign strobe_parity_on = input_check_control_r[`ICC_BIT_STROBE_PARITY];
  assign in_phase_inv_on = input_check_control_r[`ICC_BIT_IN_PHASE_INV];
  assign quad_inv_on = input_check_control_r[`ICC_BIT_QUAD_INV];
  assign two_apart_on = input_check_control_r[`ICC_BIT_TWO_APART];
  assign one_apart_on = input_check_control_r[`ICC_BIT_ONE_APART];
  assign collision_on = input_check_control_r[`ICC_BIT_COLLISION];

  // pattern test overrides both transmit enables
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_pattern_check_run <= 1'b0;
      o_analog_outputs_enable <= 1'b0;
    end else begin
      o_pattern_check_run <= test_on;
      o_analog_outputs_enable <= ~test_on & txen_s2_r &
        i_serial_tx_enable;
    end
  end

  // run counter of error-free samples; any error restarts it
  reg [6:0] good_cnt_r;
  reg [6:0] good_cnt_nxt;
  reg clear_nxt;

  always @* begin
    good_cnt_nxt = good_cnt_r;
    clear_nxt = 1'b0;
    if (!good_clear_on) begin
      good_cnt_nxt = 7'h00;
    end else if (i_sample_valid) begin
      if (i_sample_error) begin
        good_cnt_nxt = 7'h00;
      end else if (good_cnt_r == `ICC_GOOD_RUN - 7'h01) begin
        good_cnt_nxt = 7'h00;
        clear_nxt = 1'b1;
      end else begin
        good_cnt_nxt = good_cnt_r + 7'h01;
      end
    end
  end

  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      good_cnt_r <= 7'h00;
      o_alarm_auto_clear <= 1'b0;
    end else begin
      good_cnt_r <= good_cnt_nxt;
      o_alarm_auto_clear <= clear_nxt;
    end
  end

  icc_parity_check u_parity (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_check_enable(word_parity_on),
    .i_odd_sense(parity_odd_on),
    .i_use_strobe(strobe_parity_on),
    .i_valid(i_word_valid),
    .i_word(i_word),
    .i_parity_dedicated(i_dedicated_parity_input),
    .i_parity_strobe(i_strobe_parity),
    .o_parity_error(o_parity_error)
  );

  // one complement shared by both channels, each flipped by its own control bit
  function [15:0] icc_invert;
    input [15:0] data;
    input flip;
    begin
      icc_invert = flip ? ~data : data;
    end
  endfunction

  // one mask shared by the three fifo alarms
  function icc_gate;
    input raw;
    input enable;
    begin
      icc_gate = raw & enable;
    end
  endfunction

  // channel inversion equals swapping the differential legs
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_in_phase_output <= 16'h0000;
      o_quadrature_output <= 16'h0000;
    end else begin
      o_in_phase_output <= icc_invert(i_in_phase_data, in_phase_inv_on);
      o_quadrature_output <= icc_invert(i_quadrature_data, quad_inv_on);
    end
  end

  // fifo alarms pass only while their enables are set
  always @(posedge i_clk_sys or posedge i_reset) begin
    if (i_reset) begin
      o_alarm_two_apart <= 1'b0;
      o_alarm_one_apart <= 1'b0;
      o_alarm_collision <= 1'b0;
    end else begin
      o_alarm_two_apart <= icc_gate(i_fifo_two_apart, two_apart_on);
      o_alarm_one_apart <= icc_gate(i_fifo_one_apart, one_apart_on);
      o_alarm_collision <= icc_gate(i_fifo_collision, collision_on);
    end
  end

endmodule

/* icc_check_sva.sv */
// assertions on the input check control block ports
module icc_check_sva (
  input logic i_clk_sys, // clock
  input logic i_reset, // reset
  input logic i_sample_valid, // sample
  input logic i_sample_error, // sample bad
  input logic i_word_valid, // word
  input logic [15:0] i_word, // word data
  input logic i_dedicated_parity_input, // parity pin
  input logic i_strobe_parity, // strobe parity
  input logic [15:0] i_in_phase_data, // i data
  input logic [15:0] i_quadrature_data, // q data
  input logic i_fifo_two_apart, // raw alarm
  input logic i_fifo_one_apart, // raw alarm
  input logic i_fifo_collision, // raw alarm
  input logic [15:0] o_input_check_control, // register
  input logic o_pattern_check_run, // checker on
  input logic o_analog_outputs_enable, // outputs on
  input logic o_alarm_auto_clear, // clear pulse
  input logic o_parity_error, // parity pulse
  input logic [15:0] o_in_phase_output, // i out
  input logic [15:0] o_quadrature_output, // q out
  input logic o_alarm_two_apart, // gated alarm
  input logic o_alarm_one_apart, // gated alarm
  input logic o_alarm_collision // gated alarm
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_reset);
  wire [15:0] c = o_input_check_control;
  a_reset_value: assert property (disable iff (1'b0)
    i_reset |-> c == 16'h050E) else $error("reset value wrong");
  a_pattern_off: assert property (c[15] |=> o_pattern_check_run
    && !o_analog_outputs_enable) else $error("outputs left on");
  a_two_gate: assert property (o_alarm_two_apart ==
    $past(i_fifo_two_apart && c[3])) else $error("two-apart gate");
  a_one_gate: assert property (o_alarm_one_apart ==
    $past(i_fifo_one_apart && c[2])) else $error("one-apart gate");
  a_coll_gate: assert property (o_alarm_collision ==
    $past(i_fifo_collision && c[1])) else $error("collision gate");
  a_in_phase_inv: assert property (o_in_phase_output == ($past(c[6]) ?
    ~$past(i_in_phase_data) : $past(i_in_phase_data))) else $error("i inv");
  a_quad_inv: assert property (o_quadrature_output == ($past(c[5]) ?
    ~$past(i_quadrature_data) : $past(i_quadrature_data)))
    else $error("q inv");
  a_parity_flag: assert property (o_parity_error == $past(
    i_word_valid && (c[10] || c[9]) && ((^i_word ^ (c[9] ? i_strobe_parity
    : i_dedicated_parity_input)) != c[11]))) else $error("parity flag");
  a_clear_cause: assert property (o_alarm_auto_clear |->
    $past(c[12] && i_sample_valid && !i_sample_error) ##1
    !o_alarm_auto_clear) else $error("auto clear pulse");
  cover property (c[15]);
  cover property (o_alarm_auto_clear);
  cover property (o_parity_error);
endmodule

bind icc_input_check icc_check_sva i_sva (.i_clk_sys(i_clk_sys),
  .i_reset(i_reset), .i_sample_valid(i_sample_valid),
  .i_sample_error(i_sample_error), .i_word_valid(i_word_valid),
  .i_word(i_word), .i_dedicated_parity_input(i_dedicated_parity_input),
  .i_strobe_parity(i_strobe_parity), .i_in_phase_data(i_in_phase_data),
  .i_quadrature_data(i_quadrature_data),
  .i_fifo_two_apart(i_fifo_two_apart), .i_fifo_one_apart(i_fifo_one_apart),
  .i_fifo_collision(i_fifo_collision),
  .o_input_check_control(o_input_check_control),
  .o_pattern_check_run(o_pattern_check_run),
  .o_analog_outputs_enable(o_analog_outputs_enable),
  .o_alarm_auto_clear(o_alarm_auto_clear), .o_parity_error(o_parity_error),
  .o_in_phase_output(o_in_phase_output),
  .o_quadrature_output(o_quadrature_output),
  .o_alarm_two_apart(o_alarm_two_apart),
  .o_alarm_one_apart(o_alarm_one_apart),
  .o_alarm_collision(o_alarm_collision));

/* input_check_config_register_test.sv */
// scenarios for the input check control register
`include "icc_regs.vh"
module input_check_config_register_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 0, en_n = 1, sck = 0, sdi = 0, txp = 0, txs = 0;
  logic sv = 0, se = 0, wv = 0, dp = 0, sp = 0, f2 = 0, f1 = 0, fc = 0;
  logic [15:0] w = 0, di = 0, dq = 0, ctl, oi, oq, rd;
  logic sdo, oe, seen, run, aen, clr, perr, a2, a1, ac;
  int n_errors = 0, samples_checked = 0;
  icc_input_check i_icc_input_check (.i_clk_sys(clk), .i_reset(rst),
    .i_serial_enable_n(en_n), .i_serial_clk(sck), .i_serial_data_in(sdi),
    .o_serial_data_out(sdo), .o_serial_data_oe(oe), .i_tx_enable_pin(txp),
    .i_serial_tx_enable(txs), .i_sample_valid(sv), .i_sample_error(se),
    .i_word_valid(wv), .i_word(w), .i_dedicated_parity_input(dp),
    .i_strobe_parity(sp), .i_in_phase_data(di), .i_quadrature_data(dq),
    .i_fifo_two_apart(f2), .i_fifo_one_apart(f1), .i_fifo_collision(fc),
    .o_input_check_control(ctl), .o_pattern_check_run(run),
    .o_analog_outputs_enable(aen), .o_alarm_auto_clear(clr),
    .o_parity_error(perr), .o_in_phase_output(oi), .o_quadrature_output(oq),
    .o_alarm_two_apart(a2), .o_alarm_one_apart(a1), .o_alarm_collision(ac));
  initial forever #2 clk = ~clk;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // half periods of 5 clocks cover the 2-stage pin sync
  task automatic sif(input logic r, input logic [6:0] a,
                     input logic [15:0] d);
    logic [23:0] f;
    f = {r, a, d};
    seen = 0;
    en_n <= 0;
    for (int i = 23; i >= 0; i--) begin
      sdi <= f[i];
      tick(5);
      if (i < 16) begin
        rd[i] = sdo;
        seen = seen | oe;
      end
      sck <= 1;
      tick(5);
      sck <= 0;
    end
    tick(5);
    en_n <= 1;
    tick(5);
  endtask
  task automatic t_regs;
    chk(ctl, `ICC_CTRL_RESET);
    f2 <= 1; f1 <= 1; fc <= 1;
    tick(3);
    chk({a2, a1, ac}, 16'h0007);
    sif(1, `ICC_CTRL_ADDR, 16'h0000);
    chk(seen, 16'h0001);
    chk(rd, 16'h050E);
    sif(1, 7'h02, 16'h0000);
    chk(seen, 16'h0000);
    sif(0, `ICC_CTRL_ADDR, 16'hFFFF);
    sif(1, `ICC_CTRL_ADDR, 16'h0000);
    chk(rd, 16'hFFFF);
    sif(0, `ICC_CTRL_ADDR, 16'h0000);
    sif(0, 7'h02, 16'h1234);
    chk(ctl, 16'h0000);
    chk({a2, a1, ac}, 16'h0000);
  endtask
  // frame cut after 20 rises must not write
  task automatic t_abort;
    logic [23:0] f;
    f = {1'b0, `ICC_CTRL_ADDR, 16'hFFFF};
    en_n <= 0;
    for (int i = 23; i >= 4; i--) begin
      sdi <= f[i];
      tick(5);
      sck <= 1;
      tick(5);
      sck <= 0;
    end
    tick(5);
    en_n <= 1;
    tick(5);
    chk(ctl, 16'h0000);
  endtask
  task automatic t_invert;
    di <= 16'h1234; dq <= 16'hABCD;
    sif(0, `ICC_CTRL_ADDR, 16'h0060);
    chk(oi, 16'hEDCB);
    chk(oq, 16'h5432);
    sif(0, `ICC_CTRL_ADDR, 16'h0020);
    chk(oi, 16'h1234);
    chk(oq, 16'h5432);
  endtask
  // word of odd weight, dedicated bit 0, strobe bit 1
  task automatic t_parity;
    logic [15:0] m [5] = '{16'h0400, 16'h0C00, 16'h0200, 16'h0A00, 16'h0};
    logic [4:0] e = 5'b10010;
    for (int k = 0; k < 5; k++) begin
      sif(0, `ICC_CTRL_ADDR, m[k]);
      w <= 16'h0001; dp <= 0; sp <= 1; wv <= 1;
      tick(1);
      wv <= 0;
      @(negedge clk);
      chk(perr, e[4 - k]);
      @(posedge clk);
    end
  endtask
  task automatic t_clear;
    int n;
    n = 0;
    sif(0, `ICC_CTRL_ADDR, 16'h1000);
    for (int k = 0; k < 100; k++) begin
      @(posedge clk);
      sv <= (k < 95);
      se <= (k == 30);
      @(negedge clk);
      n += clr;
    end
    @(posedge clk);
    chk(n, 16'h0001);
  endtask
  task automatic t_pattern;
    txp <= 1; txs <= 1;
    sif(0, `ICC_CTRL_ADDR, 16'h0000);
    chk({run, aen}, 16'h0001);
    sif(0, `ICC_CTRL_ADDR, 16'h8000);
    chk({run, aen}, 16'h0002);
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    // rising edge at time zero so the async reset really fires
    rst <= 1;
    tick(12);
    rst <= 0;
    tick(2);
    t_regs();
    t_abort();
    t_invert();
    t_parity();
    t_clear();
    t_pattern();
    summarize();
  end
endmodule
